// ==== shared/tws_pkg.sv ====
// constants for the two-wire serial port: register map, control bit positions, states
// assumes an 8-bit special-function-register bus on the core clock
package tws_pkg;
   localparam logic [7:0] ADDR_SLAVE_ADDR = 8'h9b;
   localparam logic [7:0] ADDR_CONTROL = 8'he8;
   // data register has no printed address; chosen free slot
   localparam logic [7:0] ADDR_DATA = 8'h9a;
   localparam logic [7:0] ADDR_SPI_CONTROL = 8'hf8;
   localparam logic [7:0] RST_SLAVE_ADDR = 8'h55;
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_SPI_CONTROL = 8'h00;
   localparam int BIT_MDATA_OUT = 7;
   localparam int BIT_MDATA_EN = 6;
   localparam int BIT_MCLK_OUT = 5;
   localparam int BIT_MDATA_IN = 4;
   localparam int BIT_ROLE = 3;
   localparam int BIT_IF_RESET = 2;
   localparam int BIT_DIR = 1;
   localparam int BIT_DONE = 0;
   localparam int BIT_PORT_SEL = 5;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b011,
      ST_RX = 3'b010,
      ST_RACK = 3'b110,
      ST_TX = 3'b111,
      ST_TACK = 3'b101
   } tws_state_e;
endpackage

// ==== verilog/tws_fifo.sv ====
// byte fifo with valid/ready on both sides
// assumes a single clock domain
`timescale 1ns/10ps
`default_nettype none
module tws_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q, rd_q;
   logic push, pop;
   assign in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid = wr_q != rd_q;
   assign out_data = mem[rd_q[AW-1:0]];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (flush) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verilog/tws_port.sv ====
// two-wire serial port: software master bit-bang or hardware slave, sharing pins with spi
// assumes an 8-bit sfr bus on core_clk; pins are open drain, resolved outside
`timescale 1ns/10ps
`default_nettype none
module tws_port (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic sfr_bit_wr,
   input wire logic [2:0] sfr_bit_sel,
   input wire logic sfr_bit_val,
   output logic [7:0] sfr_rdata,
   output logic irq,
   output logic tx_ready,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   output logic spi_selected
);
   typedef struct packed {
      logic [7:0] sadr;
      logic [7:0] ctl;
      logic [7:0] spi;
      logic [7:0] rx;
      logic [7:0] shift;
      logic [7:0] rdata;
      logic [3:0] cnt;
      tws_pkg::tws_state_e st;
      logic sda_m, scl_m, sda_s, scl_s, sda_p, scl_p;
      logic hold_low;
      logic irq;
   } tws_s;
   tws_s q, d;
   logic data_acc, start_det, stop_det, scl_rise, scl_fall, fifo_pop, fifo_valid;
   logic [7:0] fifo_data;
   logic slave_rst, role_m;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   assign data_acc = (sfr_wr || sfr_rd) && hit(sfr_addr, tws_pkg::ADDR_DATA);
   assign role_m = q.ctl[tws_pkg::BIT_ROLE];
   assign slave_rst = role_m || q.ctl[tws_pkg::BIT_IF_RESET];
   assign scl_rise = q.scl_s && !q.scl_p;
   assign scl_fall = !q.scl_s && q.scl_p;
   assign start_det = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
   assign stop_det = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;

   tws_fifo #(.WIDTH(tws_pkg::FIFO_WIDTH), .DEPTH(tws_pkg::FIFO_DEPTH)) u_txq (
      .clk(core_clk),
      .rst_n(rst_n),
      .flush(slave_rst),
      .in_valid(sfr_wr && hit(sfr_addr, tws_pkg::ADDR_DATA)),
      .in_ready(tx_ready),
      .in_data(sfr_wdata),
      .out_valid(fifo_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_data)
   );

   always_comb begin
      d = q;
      fifo_pop = 1'b0;
      d.sda_m = sda_in;
      d.scl_m = scl_in;
      d.sda_s = q.sda_m;
      d.scl_s = q.scl_m;
      d.sda_p = q.sda_s;
      d.scl_p = q.scl_s;
      // register writes
      if (sfr_wr) begin
         if (hit(sfr_addr, tws_pkg::ADDR_SLAVE_ADDR)) begin
            d.sadr = sfr_wdata;
         end else if (hit(sfr_addr, tws_pkg::ADDR_CONTROL)) begin
            d.ctl = sfr_wdata;
         end else if (hit(sfr_addr, tws_pkg::ADDR_SPI_CONTROL)) begin
            d.spi = sfr_wdata;
         end
      end else if (sfr_bit_wr && hit(sfr_addr, tws_pkg::ADDR_CONTROL)) begin
         d.ctl[sfr_bit_sel] = sfr_bit_val;
      end
      if (data_acc) begin
         d.ctl[tws_pkg::BIT_DONE] = 1'b0;
         d.irq = 1'b0;
      end
      // read data
      if (hit(sfr_addr, tws_pkg::ADDR_SLAVE_ADDR)) begin
         d.rdata = q.sadr;
      end else if (hit(sfr_addr, tws_pkg::ADDR_CONTROL)) begin
         d.rdata = q.ctl;
      end else if (hit(sfr_addr, tws_pkg::ADDR_SPI_CONTROL)) begin
         d.rdata = q.spi;
      end else if (hit(sfr_addr, tws_pkg::ADDR_DATA)) begin
         d.rdata = q.rx;
      end else begin
         d.rdata = 8'h00;
      end
      if (role_m) begin
         // software master: sample data on clock rise while not driving
         if (!q.ctl[tws_pkg::BIT_MDATA_EN] && scl_rise) begin
            d.ctl[tws_pkg::BIT_MDATA_IN] = q.sda_s;
         end
      end
      if (slave_rst) begin
         d.st = tws_pkg::ST_IDLE;
         d.hold_low = 1'b0;
         d.cnt = 4'h0;
      end else if (start_det) begin
         d.st = tws_pkg::ST_ADDR;
         d.cnt = 4'h0;
         d.hold_low = 1'b0;
      end else if (stop_det) begin
         d.st = tws_pkg::ST_IDLE;
         d.hold_low = 1'b0;
      end else begin
         case (q.st)
            tws_pkg::ST_ADDR, tws_pkg::ST_RX: begin
               if (scl_rise) begin
                  d.shift = {q.shift[6:0], q.sda_s};
                  d.cnt = q.cnt + 4'h1;
               end
               if (scl_fall && q.cnt == tws_pkg::BITS_PER_BYTE) begin
                  d.cnt = 4'h0;
                  if (q.st == tws_pkg::ST_ADDR) begin
                     if (q.shift[7:1] == q.sadr[6:0]) begin
                        d.st = tws_pkg::ST_AACK;
                        d.hold_low = 1'b1;
                        d.ctl[tws_pkg::BIT_DIR] = q.shift[0];
                     end else begin
                        d.st = tws_pkg::ST_IDLE;
                     end
                  end else begin
                     d.rx = q.shift;
                     d.ctl[tws_pkg::BIT_DONE] = 1'b1;
                     d.irq = 1'b1;
                     d.st = tws_pkg::ST_RACK;
                     d.hold_low = 1'b1;
                  end
               end
            end
            tws_pkg::ST_AACK, tws_pkg::ST_RACK: begin
               if (scl_fall) begin
                  d.hold_low = 1'b0;
                  if (q.ctl[tws_pkg::BIT_DIR]) begin
                     d.st = tws_pkg::ST_TX;
                     d.shift = fifo_valid ? fifo_data : 8'hff;
                     fifo_pop = fifo_valid;
                     d.hold_low = fifo_valid ? !fifo_data[7] : 1'b0;
                  end else begin
                     d.st = tws_pkg::ST_RX;
                  end
               end
            end
            tws_pkg::ST_TX: begin
               if (scl_rise) begin
                  d.cnt = q.cnt + 4'h1;
               end
               if (scl_fall) begin
                  if (q.cnt == tws_pkg::BITS_PER_BYTE) begin
                     d.cnt = 4'h0;
                     d.hold_low = 1'b0;
                     d.st = tws_pkg::ST_TACK;
                     d.ctl[tws_pkg::BIT_DONE] = 1'b1;
                     d.irq = 1'b1;
                  end else begin
                     d.shift = {q.shift[6:0], 1'b1};
                     d.hold_low = !q.shift[6];
                  end
               end
            end
            tws_pkg::ST_TACK: begin
               if (scl_rise) begin
                  // master nack ends the read
                  d.st = q.sda_s ? tws_pkg::ST_IDLE : tws_pkg::ST_AACK;
               end
            end
            default: begin
               d.st = tws_pkg::ST_IDLE;
            end
         endcase
      end
      // byte completion only; set wins over a same-cycle clear from a data access
      if ((q.st == tws_pkg::ST_RX && d.st == tws_pkg::ST_RACK)
         || (q.st == tws_pkg::ST_TX && d.st == tws_pkg::ST_TACK)) begin
         d.ctl[tws_pkg::BIT_DONE] = 1'b1;
         d.irq = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.sadr <= tws_pkg::RST_SLAVE_ADDR;
         q.ctl <= tws_pkg::RST_CONTROL;
         q.spi <= tws_pkg::RST_SPI_CONTROL;
         q.st <= tws_pkg::ST_IDLE;
         q.sda_m <= 1'b1;
         q.scl_m <= 1'b1;
         q.sda_s <= 1'b1;
         q.scl_s <= 1'b1;
         q.sda_p <= 1'b1;
         q.scl_p <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign spi_selected = q.spi[tws_pkg::BIT_PORT_SEL];
   assign sfr_rdata = q.rdata;
   assign irq = q.irq && !spi_selected;
   // open drain: only a low is driven, enable high while pulling low
   always_comb begin
      sda_out = 1'b0;
      scl_out = 1'b0;
      sda_oe = 1'b0;
      scl_oe = 1'b0;
      if (!spi_selected) begin
         if (role_m) begin
            sda_oe = q.ctl[tws_pkg::BIT_MDATA_EN] && !q.ctl[tws_pkg::BIT_MDATA_OUT];
            scl_oe = !q.ctl[tws_pkg::BIT_MCLK_OUT];
         end else begin
            sda_oe = q.hold_low;
         end
      end
   end
endmodule
`default_nettype wire

// ==== test/tws_port_asserts.sv ====
// assertions on the sfr and pin behaviour of tws_port
// bound into every tws_port; watches its ports only
`timescale 1ns/10ps
`default_nettype none
module tws_port_asserts (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic sfr_bit_wr,
   input wire logic [7:0] sfr_rdata,
   input wire logic irq,
   input wire logic sda_oe,
   input wire logic scl_oe,
   input wire logic spi_selected,
   input wire logic scl_in
);
   // last four clock pin samples; a byte can only complete after a clock fall
   logic [3:0] scl_hist;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_hist <= 4'hf;
      end else begin
         scl_hist <= {scl_hist[2:0], scl_in};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // control byte write that selects master while two-wire is active
   wire logic mwr = sfr_wr && sfr_addr == 8'he8 && sfr_wdata[3] && !spi_selected;
   wire logic dacc = (sfr_wr || sfr_rd) && sfr_addr == 8'h9a;
   property p_clk; mwr |=> scl_oe == !$past(sfr_wdata[5]); endproperty
   a_clk: assert property (p_clk)
      else $error("clock pin");
   property p_dat; mwr |=> sda_oe == ($past(sfr_wdata[6]) && !$past(sfr_wdata[7])); endproperty
   a_dat: assert property (p_dat)
      else $error("data pin");
   property p_sel; sfr_wr && sfr_addr == 8'hf8 |=> spi_selected == $past(sfr_wdata[5]); endproperty
   a_sel: assert property (p_sel)
      else $error("port select");
   property p_quiet; spi_selected [*2] |-> !irq; endproperty
   a_quiet: assert property (p_quiet)
      else $error("request while spi");
   property p_adr; sfr_wr && sfr_addr == 8'h9b ##1 sfr_addr == 8'h9b
      |=> sfr_rdata[6:0] == $past(sfr_wdata[6:0], 2); endproperty
   a_adr: assert property (p_adr)
      else $error("address readback");
   property p_unm; sfr_addr == 8'h11 |=> sfr_rdata == 8'h00; endproperty
   a_unm: assert property (p_unm)
      else $error("unmapped read");
   property p_clr; dacc && scl_hist inside {4'h0, 4'hf} |=> !irq; endproperty
   a_clr: assert property (p_clr)
      else $error("request not cleared");
   property p_hold; irq && !dacc && !sfr_bit_wr
      && !(sfr_wr && sfr_addr inside {8'he8, 8'hf8}) |=> irq; endproperty
   a_hold: assert property (p_hold)
      else $error("request dropped");
endmodule
bind tws_port tws_port_asserts u_chk (.core_clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr,
   .sfr_rd, .sfr_bit_wr, .sfr_rdata, .irq, .sda_oe, .scl_oe, .spi_selected, .scl_in);
`default_nettype wire

// ==== test/tws_bus_master_model.sv ====
// far-side two-wire bus master with a 160 ns bit period
// open drain: pulls lines low or releases them; the bench resolves the wires
`timescale 1ns/10ps
`default_nettype none
module tws_bus_master_model (
   input wire logic sda,
   output var logic sda_low,
   output var logic scl_low
);
   initial begin
      sda_low = 1'b0;
      scl_low = 1'b0;
   end
   // hold the data line outside a frame
   task automatic drive_data(input logic low);
      sda_low = low;
   endtask
   // data set up while the clock is low, sampled mid high phase
   task automatic clk_bit(input logic drive_low, output logic level);
      sda_low = drive_low;
      #40 scl_low = 1'b0;
      #40 level = sda;
      #40 scl_low = 1'b1;
      #40;
   endtask
   task automatic start;
      sda_low = 1'b1;
      #80 scl_low = 1'b1;
      #40;
   endtask
   task automatic stop;
      sda_low = 1'b1;
      #40 scl_low = 1'b0;
      #40 sda_low = 1'b0;
      #80;
   endtask
   // msb first, then one ack clock; 8'hff releases the line to read
   task automatic xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
      output logic ack);
      logic lv;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(!tx[i], lv);
         rx[i] = lv;
      end
      clk_bit(mack, lv);
      ack = !lv;
   endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// self-checking bench for tws_port against a far-side bus master model
// sfr bus driven 1 ns after each rising edge; pull-ups on both lines
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
   $display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
   logic core_clk, rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, ack;
   logic irq, tx_ready, sda_oe, scl_oe, spi_selected, m_sda_low, m_scl_low;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d, rx, adr, rnd;
   logic [2:0] sfr_bit_sel;
   logic [7:0] exp_q[$];
   int fail_count = 0, samples_checked = 0;
   wire logic sda = !(sda_oe || m_sda_low);
   wire logic scl = !(scl_oe || m_scl_low);
   tws_port DUT (.core_clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_bit_wr,
      .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .irq, .tx_ready, .sda_in(sda), .sda_out(),
      .sda_oe, .scl_in(scl), .scl_out(), .scl_oe, .spi_selected);
   tws_bus_master_model m (.sda, .sda_low(m_sda_low), .scl_low(m_scl_low));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // k = {byte write, read, bit write}; a bit write takes {val, sel} from v[3:0]
   task automatic cyc(input logic [2:0] k, input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk) #1;
      {sfr_wr, sfr_rd, sfr_bit_wr} = k;
      sfr_addr = a;
      sfr_wdata = v;
      {sfr_bit_val, sfr_bit_sel} = v[3:0];
      @(posedge core_clk) #1;
      {sfr_wr, sfr_rd, sfr_bit_wr} = 3'b000;
      d = sfr_rdata;
   endtask
   task automatic print_verdict;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      #200000;
      fail_count++;
      print_verdict();
   end
   initial begin
      rst_n = 1'b0;
      {sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val, sfr_bit_sel} = '0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      rnd = 8'h33;
      repeat (2) @(posedge core_clk);
      #1 rst_n = 1'b1;
      `CHK({sda_oe, scl_oe, irq}, 3'b000)
      cyc(3'b010, 8'h9b, 8'h00);
      `CHK(d, 8'h55)
      cyc(3'b010, 8'he8, 8'h00);
      `CHK(d, 8'h00)
      cyc(3'b010, 8'h11, 8'h00);
      `CHK(d, 8'h00)
      rnd = lfsr(rnd);
      adr = {1'b0, rnd[6:0]};
      cyc(3'b100, 8'h9b, adr);
      cyc(3'b010, 8'h9b, 8'h00);
      `CHK(d, adr)
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         cyc(3'b100, 8'he8, {rnd[7:4], 4'h8});
         `CHK({scl_oe, sda_oe}, {!rnd[5], rnd[6] & !rnd[7]})
      end
      for (int lv = 0; lv < 2; lv++) begin
         cyc(3'b100, 8'he8, 8'h08);
         m.drive_data(!lv[0]);
         cyc(3'b001, 8'he8, 8'h0d);
         repeat (6) @(posedge core_clk);
         cyc(3'b010, 8'he8, 8'h00);
         `CHK({scl, d[5:4]}, {2'b11, lv[0]})
      end
      m.drive_data(1'b0);
      cyc(3'b100, 8'he8, 8'h00);
      cyc(3'b100, 8'hf8, 8'h20);
      `CHK(spi_selected, 1'b1)
      cyc(3'b100, 8'he8, 8'h48);
      `CHK({scl_oe, sda_oe}, 2'b00)
      cyc(3'b100, 8'he8, 8'h00);
      cyc(3'b100, 8'hf8, 8'h00);
      `CHK(spi_selected, 1'b0)
      m.start();
      m.xfer({adr[6:0], 1'b0}, 1'b0, rx, ack);
      cyc(3'b010, 8'he8, 8'h00);
      `CHK({ack, d[1]}, 2'b10)
      cyc(3'b010, 8'h9a, 8'h00);
      for (int i = 0; i < 2; i++) begin
         rnd = lfsr(rnd);
         m.xfer(rnd, 1'b0, rx, ack);
         cyc(3'b010, 8'he8, 8'h00);
         `CHK({ack, irq, d[1:0]}, 4'b1101)
         cyc(3'b010, 8'h9a, 8'h00);
         `CHK({d, irq}, {rnd, 1'b0})
      end
      m.stop();
      `CHK(irq, 1'b0)
      for (int i = 0; i < 2; i++) begin
         cyc(3'b001, 8'he8, {4'h0, i[0], 3'h2});
         m.start();
         m.xfer({adr[6:0] ^ {6'h00, !i[0]}, 1'b0}, 1'b0, rx, ack);
         `CHK(ack, 1'b0)
         m.stop();
      end
      cyc(3'b001, 8'he8, 8'h02);
      for (int i = 0; i < 9; i++) begin
         rnd = lfsr(rnd);
         exp_q.push_back(rnd);
         `CHK(tx_ready, i < 8)
         cyc(3'b100, 8'h9a, rnd);
      end
      exp_q.pop_back();
      m.start();
      m.xfer({adr[6:0], 1'b1}, 1'b0, rx, ack);
      cyc(3'b010, 8'he8, 8'h00);
      `CHK({ack, d[1]}, 2'b11)
      for (int i = 0; i < 8; i++) begin
         m.xfer(8'hff, i < 7, rx, ack);
         d = exp_q.pop_front();
         `CHK({rx, irq}, {d, 1'b1})
         cyc(3'b010, 8'h9a, 8'h00);
      end
      m.stop();
      `CHK(tx_ready, 1'b1)
      print_verdict();
   end
endmodule
`default_nettype wire
